// file: pkg/mrs_pkg.sv
// package: register map, field positions, reset values and types of the modem
package mrs_pkg;
	localparam logic [7:0] ADDR_SYNC_HIGH = 8'h00;
	localparam logic [7:0] ADDR_SYNC_LOW = 8'h04;
	localparam logic [7:0] ADDR_CFG_SYNC = 8'h08;
	localparam logic [7:0] ADDR_CFG_RATE_LOW = 8'h0C;
	localparam logic [7:0] ADDR_CFG_RATE_BW = 8'h10;
	localparam logic [7:0] ADDR_OFFSET_CFG = 8'h14;
	localparam logic [7:0] ADDR_OFFSET_CORR = 8'h18;
	localparam logic [7:0] ADDR_OFFSET_EST = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_LEVEL = 8'h24;

	localparam logic [7:0] SYNC_HIGH_RST = 8'hA5;
	localparam logic [7:0] SYNC_LOW_RST = 8'h3C;
	localparam logic [7:0] CFG_SYNC_RST = 8'h02;
	localparam logic [7:0] CFG_RATE_LOW_RST = 8'h22;
	localparam logic [7:0] CFG_RATE_BW_RST = 8'h88;
	localparam logic [7:0] OFFSET_CFG_RST = 8'h36;

	// modem_config_sync fields
	localparam int SYNC_MODE_LSB = 0;
	localparam int MOD_FMT_LSB = 4;
	// modem_config_rate_bw fields
	localparam int RATE_E_LSB = 0;
	localparam int BW_M_LSB = 4;
	localparam int BW_E_LSB = 6;
	// offset_comp_config fields
	localparam int LIMIT_LSB = 0;
	localparam int POST_K_BIT = 2;
	localparam int PRE_K_LSB = 3;
	localparam int GATE_BIT = 5;

	localparam logic [2:0] MOD_ASK = 3'h3;
	localparam logic [3:0] RATE_E_MAX = 4'hE;
	localparam logic [8:0] RATE_BASE = 9'h100;
	localparam logic [2:0] BW_BASE = 3'h4;
	localparam logic [2:0] PH_MID = 3'h4;
	localparam logic [2:0] PH_LAST = 3'h7;
	localparam logic [5:0] SYNC_BITS_16 = 6'h10;
	localparam logic [5:0] SYNC_BITS_32 = 6'h20;
	localparam logic [5:0] THR_15_16 = 6'h0F;
	localparam logic [5:0] THR_16_16 = 6'h10;
	localparam logic [5:0] THR_30_32 = 6'h1E;
	localparam logic [2:0] POST_SHIFT_LO = 3'h3;
	localparam logic [2:0] POST_SHIFT_HI = 3'h5;

	typedef enum logic [1:0] {
		SYNC_OFF,
		SYNC_15_16,
		SYNC_16_16,
		SYNC_30_32
	} mrs_sync_mode_e;

	typedef struct packed {
		logic [7:0] rate_mantissa;
		logic [3:0] rate_exponent;
		logic [1:0] bandwidth_mantissa;
		logic [1:0] bandwidth_exponent;
	} mrs_cfg_s;
endpackage

// file: rtl/mrs_rate_gen.sv
// phase accumulator making eight sample ticks per symbol from rate settings
`timescale 1ns/1ps
`default_nettype none
module mrs_rate_gen (
	input wire logic clk,
	input wire logic reset_n,
	input wire mrs_pkg::mrs_cfg_s cfg,
	output logic sample_tick
);
	logic [27:0] acc_reg;
	logic [27:0] inc;
	logic [28:0] sum;

	// increment is (256+m)<<e, times eight for oversampling; the top
	// value stays below 2**27 so ticks can never come back to back
	assign inc = 28'(({19'h0, mrs_pkg::RATE_BASE + {1'b0, cfg.rate_mantissa}}
		<< cfg.rate_exponent) << 3);
	assign sum = {1'b0, acc_reg} + {1'b0, inc};

	// carry out of the 28-bit accumulator is the tick
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			acc_reg <= 28'h0000000;
			sample_tick <= 1'b0;
		end else begin
			acc_reg <= sum[27:0];
			sample_tick <= sum[28];
		end
	end

	a_tick_spacing: assert property (@(posedge clk) disable iff (!reset_n)
		sample_tick |=> !sample_tick)
		else $error("sample ticks came back to back");
endmodule
`default_nettype wire

// file: rtl/mrs_modem.sv
// modem core: apb registers, bit/byte sync, sync insertion, offset tracking
`timescale 1ns/1ps
`default_nettype none
module mrs_modem (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_enable,
	input wire logic rx_symbol,
	input wire logic rx_freq_valid,
	input wire logic [7:0] rx_freq_sample,
	input wire logic [7:0] rx_level,
	input wire logic carrier_sense,
	input wire logic tx_start,
	input wire logic tx_stop,
	input wire logic tx_payload_bit,
	output logic tx_bit,
	output logic tx_active,
	output logic tx_bit_req,
	output logic [7:0] rx_byte,
	output logic rx_byte_valid,
	output logic sync_found,
	output logic [7:0] synth_offset,
	output logic [8:0] filter_divisor
);
	logic [7:0] sync_high_byte_reg;
	logic [7:0] sync_low_byte_reg;
	logic [7:0] modem_config_sync_reg;
	logic [7:0] modem_config_rate_low_reg;
	logic [7:0] modem_config_rate_bw_reg;
	logic [7:0] offset_comp_config_reg;
	logic [7:0] offset_correction_reg;
	logic [7:0] offset_estimate_reg;
	logic [7:0] level_reg;
	logic sync_seen_reg;
	mrs_pkg::mrs_cfg_s cfg_reg;
	logic apb_setup_done;
	logic apb_write;
	logic [31:0] rd_data;
	logic rd_hit;
	logic sample_tick;

	// number of agreeing bits under a mask
	function automatic logic [5:0] agree(input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] mask);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 0; i < 32; i++) begin
			n = n + {5'h00, ~(a[i] ^ b[i]) & mask[i]};
		end
		return n;
	endfunction

	// limit code to tracking bound, a fraction of the channel
	function automatic logic [7:0] limit_of(input logic [1:0] code);
		case (code)
			2'h0: return 8'h00;
			2'h1: return 8'h10;
			2'h2: return 8'h20;
			default: return 8'h40;
		endcase
	endfunction

	// apb: one wait cycle, data and error registered with pready
	assign apb_setup_done = psel & penable & ~pready;
	assign apb_write = psel & penable & pready & pwrite;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup_done;
			if (apb_setup_done) begin
				prdata <= pwrite ? 32'h00000000 : rd_data;
				pslverr <= ~rd_hit;
			end
		end
	end

	// read decode; unmapped offsets read zero and answer with an error
	always_comb begin
		rd_data = 32'h00000000;
		rd_hit = 1'b1;
		case (paddr)
			mrs_pkg::ADDR_SYNC_HIGH: rd_data[7:0] = sync_high_byte_reg;
			mrs_pkg::ADDR_SYNC_LOW: rd_data[7:0] = sync_low_byte_reg;
			mrs_pkg::ADDR_CFG_SYNC: rd_data[7:0] = modem_config_sync_reg;
			mrs_pkg::ADDR_CFG_RATE_LOW: rd_data[7:0] = modem_config_rate_low_reg;
			mrs_pkg::ADDR_CFG_RATE_BW: rd_data[7:0] = modem_config_rate_bw_reg;
			mrs_pkg::ADDR_OFFSET_CFG: rd_data[7:0] = offset_comp_config_reg;
			mrs_pkg::ADDR_OFFSET_CORR: rd_data[7:0] = offset_correction_reg;
			mrs_pkg::ADDR_OFFSET_EST: rd_data[7:0] = offset_estimate_reg;
			mrs_pkg::ADDR_STATUS: rd_data[3:0] = {sync_seen_reg, carrier_sense,
				tx_active, rx_enable};
			mrs_pkg::ADDR_LEVEL: rd_data[7:0] = level_reg;
			default: rd_hit = 1'b0;
		endcase
	end

	// writable configuration; the write lands on the pready edge only
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync_high_byte_reg <= mrs_pkg::SYNC_HIGH_RST;
			sync_low_byte_reg <= mrs_pkg::SYNC_LOW_RST;
			modem_config_sync_reg <= mrs_pkg::CFG_SYNC_RST;
			modem_config_rate_low_reg <= mrs_pkg::CFG_RATE_LOW_RST;
			modem_config_rate_bw_reg <= mrs_pkg::CFG_RATE_BW_RST;
			offset_comp_config_reg <= mrs_pkg::OFFSET_CFG_RST;
			offset_correction_reg <= 8'h00;
		end else if (apb_write) begin
			case (paddr)
				mrs_pkg::ADDR_SYNC_HIGH: sync_high_byte_reg <= pwdata[7:0];
				mrs_pkg::ADDR_SYNC_LOW: sync_low_byte_reg <= pwdata[7:0];
				mrs_pkg::ADDR_CFG_SYNC: modem_config_sync_reg <= pwdata[7:0];
				mrs_pkg::ADDR_CFG_RATE_LOW: modem_config_rate_low_reg <= pwdata[7:0];
				mrs_pkg::ADDR_CFG_RATE_BW: modem_config_rate_bw_reg <= pwdata[7:0];
				mrs_pkg::ADDR_OFFSET_CFG: offset_comp_config_reg <= pwdata[7:0];
				mrs_pkg::ADDR_OFFSET_CORR: offset_correction_reg <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// synthesizer retune follows the correction field one cycle later
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			synth_offset <= 8'h00;
		end else begin
			synth_offset <= offset_correction_reg;
		end
	end

	// rate and bandwidth are taken only while idle, so a rewrite cannot
	// tear a symbol in flight; exponent clamped to the top of the span
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg_reg <= '0;
		end else if (!rx_enable && !tx_active) begin
			cfg_reg.rate_mantissa <= modem_config_rate_low_reg;
			cfg_reg.rate_exponent <= (modem_config_rate_bw_reg[3:0] >
				mrs_pkg::RATE_E_MAX) ? mrs_pkg::RATE_E_MAX :
				modem_config_rate_bw_reg[3:0];
			cfg_reg.bandwidth_mantissa <=
				modem_config_rate_bw_reg[mrs_pkg::BW_M_LSB +: 2];
			cfg_reg.bandwidth_exponent <=
				modem_config_rate_bw_reg[mrs_pkg::BW_E_LSB +: 2];
		end
	end

	// filter decimation 8*(4+m)*2^e, clock divided by it is the bandwidth
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			filter_divisor <= 9'h000;
		end else begin
			filter_divisor <= 9'({6'h00, mrs_pkg::BW_BASE +
				{1'b0, cfg_reg.bandwidth_mantissa}} <<
				(3 + cfg_reg.bandwidth_exponent));
		end
	end

	// signal strength: leaky average of the channel level
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			level_reg <= 8'h00;
		end else if (rx_enable) begin
			level_reg <= level_reg - {2'b00, level_reg[7:2]} +
				{2'b00, rx_level[7:2]};
		end
	end

	mrs_rate_gen u_rate_gen (
		.clk(clk),
		.reset_n(reset_n),
		.cfg(cfg_reg),
		.sample_tick(sample_tick)
	);

	// bit sync: eight phases a symbol, edges pull the phase toward zero
	logic [2:0] phase_reg;
	logic sym_prev_reg;
	logic bit_sample;
	assign bit_sample = rx_enable & sample_tick & (phase_reg == mrs_pkg::PH_MID);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			phase_reg <= 3'h0;
			sym_prev_reg <= 1'b0;
		end else if (sample_tick) begin
			sym_prev_reg <= rx_symbol;
			if (rx_symbol != sym_prev_reg && phase_reg != 3'h0) begin
				// late edge: hold a step; early edge: skip a step
				phase_reg <= phase_reg[2] ? phase_reg + 3'h2 : phase_reg;
			end else begin
				phase_reg <= phase_reg + 3'h1;
			end
		end
	end

	// sync correlation on the bit history including the newest bit
	logic [31:0] rx_shift_reg;
	logic [31:0] rx_shift_next;
	logic [31:0] sync_pattern;
	logic [1:0] sync_mode;
	logic sync_hit;
	logic [2:0] rx_cnt_reg;
	logic rx_accept;
	assign rx_shift_next = {rx_shift_reg[30:0], rx_symbol};
	assign sync_pattern = {sync_high_byte_reg, sync_low_byte_reg,
		sync_high_byte_reg, sync_low_byte_reg};
	assign sync_mode = modem_config_sync_reg[mrs_pkg::SYNC_MODE_LSB +: 2];

	always_comb begin
		sync_hit = 1'b0;
		case (mrs_pkg::mrs_sync_mode_e'(sync_mode))
			mrs_pkg::SYNC_15_16: sync_hit = agree(rx_shift_next, sync_pattern,
				32'h0000FFFF) >= mrs_pkg::THR_15_16;
			mrs_pkg::SYNC_16_16: sync_hit = agree(rx_shift_next, sync_pattern,
				32'h0000FFFF) == mrs_pkg::THR_16_16;
			mrs_pkg::SYNC_30_32: sync_hit = agree(rx_shift_next, sync_pattern,
				32'hFFFFFFFF) >= mrs_pkg::THR_30_32;
			default: sync_hit = 1'b0;
		endcase
		sync_hit = sync_hit & bit_sample;
	end
	// with detection on, bytes flow only after a matched sync
	assign rx_accept = (sync_mode == 2'h0) | sync_seen_reg;

	// shift register, byte counter and sync flag; hit realigns bytes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rx_shift_reg <= 32'h00000000;
			rx_cnt_reg <= 3'h0;
			sync_seen_reg <= 1'b0;
			sync_found <= 1'b0;
			rx_byte <= 8'h00;
			rx_byte_valid <= 1'b0;
		end else begin
			sync_found <= sync_hit;
			rx_byte_valid <= 1'b0;
			if (sync_hit) begin
				sync_seen_reg <= 1'b1;
			end else if (!rx_enable) begin
				sync_seen_reg <= 1'b0;
			end
			if (bit_sample) begin
				rx_shift_reg <= rx_shift_next;
				rx_cnt_reg <= sync_hit ? 3'h0 : rx_cnt_reg + 3'h1;
				if (!sync_hit && rx_cnt_reg == mrs_pkg::PH_LAST && rx_accept) begin
					rx_byte <= rx_shift_next[7:0];
					rx_byte_valid <= 1'b1;
				end
			end
		end
	end

	// offset tracking: first-order loop, gain shift set by sync state
	logic signed [8:0] smp_ext;
	logic signed [8:0] est_ext;
	logic signed [8:0] afc_diff;
	logic signed [8:0] afc_step;
	logic signed [9:0] afc_sum;
	logic signed [9:0] afc_lim;
	logic [2:0] afc_shift;
	logic afc_ask;
	logic afc_frozen;
	assign smp_ext = {rx_freq_sample[7], rx_freq_sample};
	assign est_ext = {offset_estimate_reg[7], offset_estimate_reg};
	assign afc_diff = smp_ext - est_ext;
	assign afc_shift = sync_seen_reg ?
		(offset_comp_config_reg[mrs_pkg::POST_K_BIT] ?
		mrs_pkg::POST_SHIFT_HI : mrs_pkg::POST_SHIFT_LO) :
		{1'b0, offset_comp_config_reg[mrs_pkg::PRE_K_LSB +: 2]} + 3'h1;
	assign afc_step = afc_diff >>> afc_shift;
	assign afc_sum = {est_ext[8], est_ext} + {afc_step[8], afc_step};
	assign afc_lim = {2'b00,
		limit_of(offset_comp_config_reg[mrs_pkg::LIMIT_LSB +: 2])};
	assign afc_ask = modem_config_sync_reg[mrs_pkg::MOD_FMT_LSB +: 3] ==
		mrs_pkg::MOD_ASK;
	assign afc_frozen = offset_comp_config_reg[mrs_pkg::GATE_BIT] &
		~carrier_sense;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			offset_estimate_reg <= 8'h00;
		end else if (afc_ask) begin
			offset_estimate_reg <= 8'h00;
		end else if (rx_enable && rx_freq_valid && !afc_frozen) begin
			if (afc_sum > afc_lim) begin
				offset_estimate_reg <= afc_lim[7:0];
			end else if (afc_sum < -afc_lim) begin
				offset_estimate_reg <= 8'(-afc_lim);
			end else begin
				offset_estimate_reg <= afc_sum[7:0];
			end
		end
	end

	// transmit: sync word shifted out msb first before any payload
	logic [2:0] tx_phase_reg;
	logic [31:0] tx_shift_reg;
	logic [5:0] tx_left_reg;
	logic tx_sym;
	assign tx_sym = sample_tick & (tx_phase_reg == mrs_pkg::PH_LAST);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tx_phase_reg <= 3'h0;
			tx_shift_reg <= 32'h00000000;
			tx_left_reg <= 6'h00;
			tx_active <= 1'b0;
			tx_bit <= 1'b0;
			tx_bit_req <= 1'b0;
		end else begin
			tx_bit_req <= 1'b0;
			if (sample_tick) begin
				tx_phase_reg <= tx_phase_reg + 3'h1;
			end
			if (!tx_active) begin
				if (tx_start) begin
					tx_active <= 1'b1;
					tx_shift_reg <= sync_pattern;
					tx_left_reg <= (sync_mode == 2'h3) ?
						mrs_pkg::SYNC_BITS_32 : mrs_pkg::SYNC_BITS_16;
				end
			end else if (tx_stop) begin
				tx_active <= 1'b0;
				tx_bit <= 1'b0;
			end else if (tx_sym) begin
				if (tx_left_reg != 6'h00) begin
					tx_bit <= tx_shift_reg[31];
					tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
					tx_left_reg <= tx_left_reg - 6'h01;
				end else begin
					tx_bit <= tx_payload_bit;
					tx_bit_req <= 1'b1;
				end
			end
		end
	end

	// checks on the datapath
	sequence s_corr_write;
		apb_write && paddr == mrs_pkg::ADDR_OFFSET_CORR;
	endsequence
	sequence s_tx_begin;
		tx_start && !tx_active;
	endsequence

	a_retune_follows: assert property (@(posedge clk) disable iff (!reset_n)
		s_corr_write |=> ##1 synth_offset == $past(pwdata[7:0], 2))
		else $error("synth offset did not follow correction write");
	a_ask_no_track: assert property (@(posedge clk) disable iff (!reset_n)
		afc_ask |=> offset_estimate_reg == 8'h00)
		else $error("offset tracked under ask");
	a_gate_freeze: assert property (@(posedge clk) disable iff (!reset_n)
		afc_frozen && !afc_ask |=> $stable(offset_estimate_reg))
		else $error("estimate moved while gated");
	// signed bound on both sides, so negative clamps are covered too
	a_limit_bound: assert property (@(posedge clk) disable iff (!reset_n)
		!afc_ask |=> !$past(rx_freq_valid && rx_enable && !afc_frozen) ||
		(est_ext <= $past(afc_lim) && est_ext >= -$past(afc_lim)))
		else $error("estimate outside tracking limit");
	a_sync_flag: assert property (@(posedge clk) disable iff (!reset_n)
		sync_hit |=> sync_found && sync_seen_reg)
		else $error("sync hit not flagged");
	a_byte_gated: assert property (@(posedge clk) disable iff (!reset_n)
		rx_byte_valid |-> $past(rx_accept))
		else $error("byte passed without sync");
	// the divisor register lags reset release by one edge, hence the second $stable one cycle later
	a_bw_divisor: assert property (@(posedge clk) disable iff (!reset_n)
		reset_n && $stable(cfg_reg) ##1 $stable(cfg_reg) |->
		filter_divisor == 9'(({6'h00,
		mrs_pkg::BW_BASE + {1'b0, cfg_reg.bandwidth_mantissa}})
		* (9'h008 << cfg_reg.bandwidth_exponent)))
		else $error("filter divisor wrong");
	a_tx_sync_first: assert property (@(posedge clk) disable iff (!reset_n)
		s_tx_begin |=> tx_active && tx_left_reg != 6'h00)
		else $error("transmit started without sync word");
	a_rate_static: assert property (@(posedge clk) disable iff (!reset_n)
		rx_enable || tx_active |=> $stable(cfg_reg))
		else $error("rate changed while busy");
endmodule
`default_nettype wire

// file: dv/mrs_air_partner.sv
// air partner: sends framed symbols and listens to the transmitter
`timescale 1ns/1ps
`default_nettype none
module mrs_air_partner (
	input wire logic clk,
	input wire logic tx_bit,
	input wire logic tx_active,
	output logic rx_symbol
);
	int sym_len = 64;
	int cap_n = 0;
	logic busy = 1'b0;
	logic cur = 1'b0;
	logic [63:0] cap = '0;

	// idle air flips every cycle so no stale level survives a frame
	initial rx_symbol = 1'b0;
	always @(posedge clk) begin
		rx_symbol <= busy ? cur : ~rx_symbol;
	end

	// one frame, msb first, each symbol sym_len cycles long
	task automatic send(input logic [63:0] bits, input int n);
		busy <= 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			cur <= bits[i];
			repeat (sym_len) @(posedge clk);
		end
		busy <= 1'b0;
	endtask

	// lock on the first rising symbol, then sample mid-symbol
	initial forever begin
		int k;
		wait (tx_active === 1'b1);
		cap_n = 0;
		k = 0;
		while (tx_bit !== 1'b1 && k < 200) begin
			@(posedge clk);
			k++;
		end
		repeat (sym_len / 2) @(posedge clk);
		while (tx_active === 1'b1 && cap_n < 64) begin
			cap = {cap[62:0], tx_bit};
			cap_n++;
			repeat (sym_len) @(posedge clk);
		end
		wait (tx_active !== 1'b1);
	end
endmodule
`default_nettype wire

// file: dv/mrs_modem_bench.sv
// self-checking bench of the modem core against the air partner
`timescale 1ns/1ps
`default_nettype none
module mrs_modem_bench;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
	logic rx_enable, rx_symbol, rx_freq_valid, carrier_sense, tx_start;
	logic tx_stop, tx_payload_bit, tx_bit, tx_active, tx_bit_req;
	logic rx_byte_valid, sync_found;
	logic [7:0] paddr, rx_freq_sample, rx_level, rx_byte, synth_offset;
	logic [7:0] pay_sh, first_byte, hi, lo, pay;
	logic [8:0] filter_divisor, ex;
	logic [31:0] pwdata, prdata, rd;
	logic [16:0] seed;
	int err_total, n_compared, n_sync, n_bytes, n_after;
	logic [7:0] rst_tab [7] = '{mrs_pkg::SYNC_HIGH_RST,
		mrs_pkg::SYNC_LOW_RST, mrs_pkg::CFG_SYNC_RST,
		mrs_pkg::CFG_RATE_LOW_RST, mrs_pkg::CFG_RATE_BW_RST,
		mrs_pkg::OFFSET_CFG_RST, 8'h00};

	mrs_modem DUT (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_enable(rx_enable), .rx_symbol(rx_symbol),
		.rx_freq_valid(rx_freq_valid), .rx_freq_sample(rx_freq_sample),
		.rx_level(rx_level), .carrier_sense(carrier_sense),
		.tx_start(tx_start), .tx_stop(tx_stop),
		.tx_payload_bit(tx_payload_bit), .tx_bit(tx_bit),
		.tx_active(tx_active), .tx_bit_req(tx_bit_req), .rx_byte(rx_byte),
		.rx_byte_valid(rx_byte_valid), .sync_found(sync_found),
		.synth_offset(synth_offset), .filter_divisor(filter_divisor));
	mrs_air_partner air (.clk(clk), .tx_bit(tx_bit),
		.tx_active(tx_active), .rx_symbol(rx_symbol));

	// payload rotates one bit per consumed symbol
	assign tx_payload_bit = pay_sh[7];
	always @(posedge clk) begin
		if (tx_bit_req === 1'b1)
			pay_sh <= {pay_sh[6:0], pay_sh[7]};
	end

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// keep the first byte after the latest sync hit; earlier hits are noise
	always @(posedge clk) begin
		if (sync_found === 1'b1) begin
			n_sync++;
			n_after = 0;
		end
		if (rx_byte_valid === 1'b1) begin
			if (n_after == 0)
				first_byte = rx_byte;
			n_bytes++;
			n_after++;
		end
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (i == 16) begin
			err_total++;
			stop_test();
		end
	endtask

	function automatic logic [7:0] rnd();
		for (int i = 0; i < 8; i++)
			seed = {seed[15:0], seed[16] ^ seed[13]};
		return seed[7:0];
	endfunction

	function automatic logic [8:0] div_exp(input logic [3:0] c);
		return (9'h020 + {4'h0, c[1:0], 3'h0}) << c[3:2];
	endfunction

	task automatic feed(input logic [7:0] v, input int n);
		rx_freq_sample <= v;
		rx_freq_valid <= 1'b1;
		repeat (n) @(posedge clk);
		rx_freq_valid <= 1'b0;
		apb(1'b0, mrs_pkg::ADDR_OFFSET_EST, 32'h0);
	endtask

	// dropping the receiver clears the sync flag, so mode is set with it low
	task automatic rx_case(input logic [1:0] md, input logic [31:0] fl,
		input logic ok);
		logic [7:0] p;
		logic [63:0] fr;
		p = rnd();
		if (md == 2'h3)
			fr = {24'h0, 32'hD391D391 ^ fl, p};
		else
			fr = {40'h0, 16'hD391 ^ fl[15:0], p};
		rx_enable <= 1'b0;
		apb(1'b1, mrs_pkg::ADDR_CFG_SYNC, {30'h0, md});
		rx_enable <= 1'b1;
		@(negedge clk);
		n_sync = 0;
		n_bytes = 0;
		n_after = 0;
		@(posedge clk);
		air.send(fr, (md == 2'h3) ? 40 : 24);
		repeat (768) @(posedge clk);
		chk("sync hit", {63'h0, ok}, {63'h0, n_sync > 0});
		if (ok)
			chk("rx byte", p, first_byte);
		else
			chk("bytes refused", 64'h0, n_bytes);
	endtask

	initial begin
		seed = 17'h13201;
		{reset_n, psel, penable, pwrite, rx_enable, rx_freq_valid} = '0;
		{carrier_sense, tx_start, tx_stop} = '0;
		{paddr, pwdata, rx_freq_sample, rx_level, pay_sh} = '0;
		{err_total, n_compared, n_sync, n_bytes, n_after} = '0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk("reset value", rst_tab[i], rd);
		end
		apb(1'b0, 8'h28, 32'h0);
		chk("unmapped", 64'h1_0000_0000, {er, rd});
		apb(1'b1, mrs_pkg::ADDR_OFFSET_EST, 32'hFF);
		apb(1'b0, mrs_pkg::ADDR_OFFSET_EST, 32'h0);
		chk("estimate read only", 64'h0, rd);
		for (int c = 0; c < 16; c++) begin
			ex = div_exp(4'(c));
			apb(1'b1, mrs_pkg::ADDR_CFG_RATE_BW, {24'h0, 4'(c), 4'hE});
			for (int k = 0; k < 8 && filter_divisor !== ex; k++)
				@(posedge clk);
			chk("filter divisor", ex, filter_divisor);
		end
		hi = rnd();
		apb(1'b1, mrs_pkg::ADDR_OFFSET_CORR, {24'h0, hi});
		@(posedge clk);
		chk("synth offset", hi, synth_offset);
		// level only averages with the receiver on; low two bits may lag
		rx_level <= rnd();
		rx_enable <= 1'b1;
		repeat (64) @(posedge clk);
		apb(1'b0, mrs_pkg::ADDR_LEVEL, 32'h0);
		chk("level", rx_level[7:2], rd[7:2]);
		// gate on, limit 64, pre gain shift 3; no carrier yet
		apb(1'b1, mrs_pkg::ADDR_OFFSET_CFG, 32'h33);
		rx_enable <= 1'b1;
		feed(8'h7F, 20);
		chk("gated estimate", 64'h0, rd);
		carrier_sense <= 1'b1;
		feed(8'h7F, 1);
		chk("pre-sync step", 64'hF, rd);
		feed(8'h7F, 200);
		chk("limit 64", 64'h40, rd);
		apb(1'b1, mrs_pkg::ADDR_OFFSET_CFG, 32'h31);
		feed(8'h80, 200);
		chk("limit 16", 64'hF0, rd);
		rx_enable <= 1'b0;
		apb(1'b1, mrs_pkg::ADDR_CFG_SYNC, 32'h32);
		rx_enable <= 1'b1;
		feed(8'h7F, 50);
		chk("ask estimate", 64'h0, rd);
		// exponent 14 with mantissa 0: exactly 64 cycles per symbol
		rx_enable <= 1'b0;
		apb(1'b1, mrs_pkg::ADDR_SYNC_HIGH, 32'hD3);
		apb(1'b1, mrs_pkg::ADDR_SYNC_LOW, 32'h91);
		apb(1'b1, mrs_pkg::ADDR_CFG_RATE_LOW, 32'h0);
		apb(1'b1, mrs_pkg::ADDR_CFG_RATE_BW, 32'h0E);
		rx_case(2'h1, 32'h0000_0400, 1'b1);
		rx_case(2'h2, 32'h0, 1'b1);
		rx_case(2'h2, 32'h0000_0010, 1'b0);
		rx_case(2'h3, 32'h0100_0008, 1'b1);
		// sync now seen: post gain bit set gives shift 5, not the pre shift
		apb(1'b1, mrs_pkg::ADDR_OFFSET_CFG, 32'h37);
		feed(8'h7F, 1);
		chk("post-sync step", 64'h3, rd);
		rx_case(2'h3, 32'h0100_8008, 1'b0);
		rx_enable <= 1'b0;
		// exponent 15 must be held at 14, keeping 64 cycles per symbol
		hi = rnd() | 8'h80;
		lo = rnd();
		pay = rnd();
		apb(1'b1, mrs_pkg::ADDR_SYNC_HIGH, {24'h0, hi});
		apb(1'b1, mrs_pkg::ADDR_SYNC_LOW, {24'h0, lo});
		apb(1'b1, mrs_pkg::ADDR_CFG_SYNC, 32'h03);
		apb(1'b1, mrs_pkg::ADDR_CFG_RATE_BW, 32'h0F);
		pay_sh <= pay;
		tx_start <= 1'b1;
		@(posedge clk);
		tx_start <= 1'b0;
		#1 chk("tx active", 64'h1, tx_active);
		repeat (1280) @(posedge clk);
		tx_start <= 1'b1;
		@(posedge clk);
		tx_start <= 1'b0;
		for (int k = 0; k < 3000 && air.cap_n < 40; k++)
			@(posedge clk);
		chk("tx stream", {hi, lo, hi, lo, pay}, air.cap[39:0]);
		tx_stop <= 1'b1;
		@(posedge clk);
		tx_stop <= 1'b0;
		for (int k = 0; k < 100 && tx_active !== 1'b0; k++)
			@(posedge clk);
		chk("tx idle", 64'h0, {tx_active, tx_bit});
		stop_test();
	end
endmodule
`default_nettype wire
